// ==== verilog/lcd_ctrl.sv ====
// host interface, command decoder and reset defaults of the lcd driver
`timescale 1ns/10ps
module lcd_ctrl (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_hw_reset_in_n,
  input wire logic [1:0] i_if_mode,
  input wire logic i_cs_n,
  input wire logic i_cmd_data_select,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_data,
  input wire logic i_sclk,
  input wire logic i_sdata,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_display_on,
  output logic o_invert,
  output logic o_seg_reverse,
  output logic [2:0] o_power_ctrl,
  output logic o_bias_alt,
  output logic o_all_on,
  output logic o_power_save,
  output logic o_rmw,
  output logic [1:0] o_static_ind,
  output logic [5:0] o_start_line,
  output logic [3:0] o_page,
  output logic [7:0] o_column,
  output logic o_com_reverse,
  output logic [2:0] o_reg_ratio,
  output logic [5:0] o_volume,
  output logic o_test_mode,
  output logic o_display_clock_out,
  output logic o_frame_polarity_out,
  output logic o_static_drive_out,
  output logic o_display_blank_out_n
);
  // ---------------------------------------------------------------
  // host strobe capture
  // ---------------------------------------------------------------
  lcd_fifo_if cap_s();
  lcd_fifo_if dec_s();
  logic hw_rst;
  logic rd_act;
  logic wr_act;
  logic rd_prev;
  logic wr_prev;
  logic sclk_prev;
  logic [7:0] shreg;
  logic [2:0] shcnt;
  logic par_wr;
  logic par_rd;
  logic ser_byte;
  logic [7:0] ser_word;
  logic cap_valid;
  logic [8:0] cap_data;
  logic rd_start;
  logic ram_rd_pend;
  logic [7:0] rd_latch;
  logic [7:0] ram_rdata;
  logic ram_we;
  logic [lcd_pkg::LCD_RAM_AW-1:0] ram_addr;
  logic vol_wait;
  logic ratio_wait;
  logic [5:0] next_volume;
  logic soft_rst;
  logic busy;
  lcd_pkg::lcd_mode_e mode;

  assign hw_rst = !i_resetn || !i_hw_reset_in_n;
  assign mode = lcd_pkg::lcd_mode_e'(i_if_mode);

  // strobe is active when low in 8080 mode, enable high in 6800 mode
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    case (mode)
      lcd_pkg::lcd_if_8080: begin
        rd_act = !i_cs_n && !i_rd_n;
        wr_act = !i_cs_n && !i_wr_n;
      end
      lcd_pkg::lcd_if_6800: begin
        rd_act = !i_cs_n && i_rd_n && i_wr_n;
        wr_act = !i_cs_n && i_rd_n && !i_wr_n;
      end
      default: begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (hw_rst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
      sclk_prev <= i_sclk;
    end
  end

  // writes launch at the trailing edge of the pulse, data then stable
  assign par_wr = wr_prev && !wr_act;
  assign rd_start = rd_act && !rd_prev;
  assign par_rd = rd_start;
  assign ser_word = {shreg[6:0], i_sdata};
  assign ser_byte = (mode == lcd_pkg::lcd_if_serial) &&
    !i_cs_n && i_sclk && !sclk_prev && (shcnt == 3'h7);

  always_ff @(posedge i_clk) begin
    if (hw_rst) begin
      shreg <= 8'h00;
      shcnt <= 3'h0;
    end else if (i_cs_n) begin
      shcnt <= 3'h0;
    end else if ((mode == lcd_pkg::lcd_if_serial) &&
                 i_sclk && !sclk_prev) begin
      shreg <= ser_word;
      shcnt <= shcnt + 3'h1;
    end
  end

  // a full fifo drops the transfer; host cycle time keeps it from filling
  assign cap_valid = par_wr || ser_byte;
  assign cap_data = {i_cmd_data_select, ser_byte ? ser_word : i_data};
  assign cap_s.valid = cap_valid;
  assign cap_s.data = cap_data;

  lcd_fifo #(
    .WIDTH(lcd_pkg::LCD_FIFO_WIDTH),
    .DEPTH(lcd_pkg::LCD_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(!hw_rst),
    .in_s(cap_s.snk),
    .out_s(dec_s.src)
  );

  // ---------------------------------------------------------------
  // command decoder
  // ---------------------------------------------------------------
  logic [7:0] cmd;
  logic is_data;
  logic take;
  assign cmd = dec_s.data[7:0];
  assign is_data = dec_s.data[8];
  // reads share the ram port, so decoding waits on a pending read
  assign dec_s.ready = !ram_rd_pend && !par_rd;
  assign take = dec_s.valid && dec_s.ready;
  assign busy = dec_s.valid;
  assign soft_rst = take && !is_data && !vol_wait && !ratio_wait &&
    (cmd == lcd_pkg::LCD_CMD_RESET);

  function automatic logic is_cmd(input logic [7:0] b,
                                  input logic [7:0] code,
                                  input logic [7:0] mask);
    is_cmd = ((b & mask) == code);
  endfunction

  always_ff @(posedge i_clk) begin
    if (hw_rst) begin
      o_display_on <= 1'b0;
      o_invert <= 1'b0;
      o_seg_reverse <= 1'b0;
      o_power_ctrl <= 3'h0;
      o_bias_alt <= 1'b0;
      o_all_on <= 1'b0;
      o_power_save <= 1'b0;
    end else if (take && !is_data && !vol_wait && !ratio_wait) begin
      if (is_cmd(cmd, lcd_pkg::LCD_CMD_DISP, lcd_pkg::LCD_MASK_DISP)) begin
        o_display_on <= cmd[0];
        o_power_save <= !cmd[0] && o_all_on;
      end else if (is_cmd(cmd, lcd_pkg::LCD_CMD_ALLON,
                          lcd_pkg::LCD_MASK_DISP)) begin
        o_all_on <= cmd[0];
        o_power_save <= cmd[0] && !o_display_on;
      end else if (is_cmd(cmd, lcd_pkg::LCD_CMD_ADC,
                          lcd_pkg::LCD_MASK_DISP)) begin
        o_seg_reverse <= cmd[0];
      end else if (is_cmd(cmd, lcd_pkg::LCD_CMD_BIAS,
                          lcd_pkg::LCD_MASK_DISP)) begin
        o_bias_alt <= cmd[0];
      end else if (is_cmd(cmd, lcd_pkg::LCD_CMD_INV,
                          lcd_pkg::LCD_MASK_DISP)) begin
        o_invert <= cmd[0];
      end else if (is_cmd(cmd, lcd_pkg::LCD_CMD_PWR,
                          lcd_pkg::LCD_MASK_PWR)) begin
        o_power_ctrl <= cmd[2:0];
      end
    end
  end

  // shared defaults: hardware reset and the reset command
  always_ff @(posedge i_clk) begin
    if (hw_rst || soft_rst) begin
      o_rmw <= 1'b0;
      o_static_ind <= 2'h0;
      o_start_line <= 6'h00;
      o_com_reverse <= 1'b0;
      o_reg_ratio <= 3'h0;
      o_test_mode <= 1'b0;
      vol_wait <= 1'b0;
      ratio_wait <= 1'b0;
    end else if (take && !is_data) begin
      if (vol_wait) begin
        vol_wait <= 1'b0;
      end else if (cmd[7:6] == lcd_pkg::LCD_LINE_TAG) begin
        o_start_line <= cmd[5:0];
      end else if (cmd == lcd_pkg::LCD_CMD_VOL) begin
        vol_wait <= 1'b1;
      end else if (cmd == lcd_pkg::LCD_CMD_RMW) begin
        o_rmw <= 1'b1;
      end else if (cmd == lcd_pkg::LCD_CMD_END) begin
        o_rmw <= 1'b0;
      end else if (is_cmd(cmd, lcd_pkg::LCD_CMD_COM,
                          lcd_pkg::LCD_MASK_COM)) begin
        o_com_reverse <= cmd[3];
      end
    end
  end

  assign next_volume = cmd[5:0];
  always_ff @(posedge i_clk) begin
    if (hw_rst || soft_rst) begin
      o_volume <= lcd_pkg::LCD_VOL_RST;
    end else if (take && !is_data && vol_wait) begin
      o_volume <= next_volume;
    end
  end

  // ---------------------------------------------------------------
  // page, column and display ram access
  // ---------------------------------------------------------------
  logic [7:0] rmw_col;
  logic ram_acc;
  logic wr_data;
  assign wr_data = take && is_data;
  assign ram_acc = wr_data || (par_rd && i_cmd_data_select);

  always_ff @(posedge i_clk) begin
    if (hw_rst || soft_rst) begin
      o_page <= 4'h0;
      o_column <= 8'h00;
      rmw_col <= 8'h00;
    end else if (take && !is_data && !vol_wait) begin
      if (cmd[7:4] == lcd_pkg::LCD_PAGE_TAG) begin
        o_page <= cmd[3:0];
      end else if (cmd[7:4] == lcd_pkg::LCD_COLH_TAG) begin
        o_column <= {cmd[3:0], o_column[3:0]};
      end else if (cmd[7:4] == lcd_pkg::LCD_COLL_TAG) begin
        o_column <= {o_column[7:4], cmd[3:0]};
      end else if (cmd == lcd_pkg::LCD_CMD_RMW) begin
        rmw_col <= o_column;
      end else if (cmd == lcd_pkg::LCD_CMD_END) begin
        o_column <= rmw_col;
      end
    end else if (ram_acc && !(o_rmw && !wr_data)) begin
      if (o_column < lcd_pkg::LCD_COL_MAX) begin
        o_column <= o_column + 8'h01;
      end
    end
  end

  assign ram_we = wr_data && (o_column <= lcd_pkg::LCD_COL_MAX);
  assign ram_addr = lcd_pkg::LCD_RAM_AW'(o_page[2:0] * 8'(lcd_pkg::LCD_COL_MAX
    + 8'h01) + o_column);

  lcd_ram u_ram (
    .i_clk(i_clk),
    .i_we(ram_we),
    .i_addr(ram_addr),
    .i_wdata(cmd),
    .o_rdata(ram_rdata)
  );

  // a read returns the word fetched by the previous read: dummy read
  always_ff @(posedge i_clk) begin
    if (hw_rst) begin
      ram_rd_pend <= 1'b0;
      rd_latch <= 8'h00;
    end else begin
      ram_rd_pend <= par_rd && i_cmd_data_select;
      if (ram_rd_pend) rd_latch <= ram_rdata;
    end
  end

  // ---------------------------------------------------------------
  // read data out
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (hw_rst) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= rd_act;
      if (rd_start && !i_cmd_data_select) begin
        o_data <= {busy, o_seg_reverse, !o_display_on, soft_rst, 4'h0};
      end else if (rd_start) begin
        o_data <= rd_latch;
      end
    end
  end

  // ---------------------------------------------------------------
  // display timing outputs
  // ---------------------------------------------------------------
  logic [7:0] tick;
  logic frame;
  always_ff @(posedge i_clk) begin
    if (hw_rst) begin
      tick <= 8'h00;
      frame <= 1'b1;
    end else begin
      tick <= tick + 8'h01;
      if (tick == lcd_pkg::LCD_TIMER_TOP) frame <= !frame;
    end
  end
  // timing stops and all four outputs stay high in pin reset
  assign o_display_clock_out = hw_rst || tick[0];
  assign o_frame_polarity_out = hw_rst || frame;
  assign o_static_drive_out = hw_rst || (o_static_ind != 2'h0);
  assign o_display_blank_out_n = hw_rst || o_display_on;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_pin_reset_defs: assert property (@(posedge i_clk)
    !i_hw_reset_in_n |=> !o_display_on && o_power_ctrl == 3'h0 &&
    !o_all_on && !o_power_save) else $error("pin reset defaults");
  a_soft_keeps_on: assert property (@(posedge i_clk) disable iff (hw_rst)
    soft_rst && !(take && !is_data && cmd[7:1] == 7'h57) |=>
    $stable(o_display_on) && o_column == 8'h00 &&
    o_volume == lcd_pkg::LCD_VOL_RST) else $error("soft reset");
  a_timing_high: assert property (@(posedge i_clk)
    !i_hw_reset_in_n |-> o_display_clock_out && o_frame_polarity_out)
    else $error("timing outputs");
  a_col_stops: assert property (@(posedge i_clk) disable iff (hw_rst)
    o_column == lcd_pkg::LCD_COL_MAX && ram_acc && !(take && !is_data) |=>
    o_column == lcd_pkg::LCD_COL_MAX) else $error("column wrap");
  a_line_load: assert property (@(posedge i_clk) disable iff (hw_rst)
    take && !is_data && !vol_wait && cmd[7:6] == 2'h1 && !soft_rst |=>
    o_start_line == $past(cmd[5:0])) else $error("start line");
  a_power_save: assert property (@(posedge i_clk) disable iff (hw_rst)
    take && !is_data && !vol_wait && !ratio_wait &&
    cmd == lcd_pkg::LCD_CMD_DISP &&
    o_all_on |=> o_power_save) else $error("power save");
  a_page_load: assert property (@(posedge i_clk) disable iff (hw_rst)
    take && !is_data && !vol_wait && cmd[7:4] == 4'hB |=>
    o_page == $past(cmd[3:0])) else $error("page load");
  a_disp_cmd: assert property (@(posedge i_clk) disable iff (hw_rst)
    take && !is_data && !vol_wait && !ratio_wait && cmd[7:1] == 7'h57 |=>
    o_display_on == $past(cmd[0])) else $error("display cmd");
  c_serial_byte: cover property (@(posedge i_clk) disable iff (hw_rst)
    ser_byte);
  c_col_top: cover property (@(posedge i_clk) disable iff (hw_rst)
    o_column == lcd_pkg::LCD_COL_MAX);
  c_soft_rst: cover property (@(posedge i_clk) disable iff (hw_rst)
    soft_rst);
endmodule

// ==== inc/lcd_pkg.sv ====
// constants and types of the lcd command and reset logic
package lcd_pkg;
  typedef enum logic [1:0] {lcd_if_8080, lcd_if_6800, lcd_if_serial} lcd_mode_e;
  localparam logic [7:0] LCD_COL_MAX = 8'h83;
  localparam logic [5:0] LCD_VOL_RST = 6'h20;
  localparam logic [7:0] LCD_CMD_DISP = 8'hAE;
  localparam logic [7:0] LCD_MASK_DISP = 8'hFE;
  localparam logic [7:0] LCD_CMD_ALLON = 8'hA4;
  localparam logic [7:0] LCD_CMD_RMW = 8'hE0;
  localparam logic [7:0] LCD_CMD_END = 8'hEE;
  localparam logic [7:0] LCD_CMD_RESET = 8'hE2;
  localparam logic [7:0] LCD_CMD_ADC = 8'hA0;
  localparam logic [7:0] LCD_CMD_BIAS = 8'hA2;
  localparam logic [7:0] LCD_CMD_INV = 8'hA6;
  localparam logic [7:0] LCD_CMD_PWR = 8'h28;
  localparam logic [7:0] LCD_MASK_PWR = 8'hF8;
  localparam logic [7:0] LCD_CMD_COM = 8'hC0;
  localparam logic [7:0] LCD_MASK_COM = 8'hF0;
  localparam logic [7:0] LCD_CMD_VOL = 8'h81;
  localparam logic [7:0] LCD_CMD_NOP = 8'hE3;
  localparam logic [1:0] LCD_LINE_TAG = 2'h1;
  localparam logic [3:0] LCD_PAGE_TAG = 4'hB;
  localparam logic [3:0] LCD_COLH_TAG = 4'h1;
  localparam logic [3:0] LCD_COLL_TAG = 4'h0;
  localparam int LCD_FIFO_DEPTH = 8;
  localparam int LCD_FIFO_WIDTH = 9;
  localparam int LCD_RAM_WORDS = 1056;
  localparam int LCD_RAM_AW = 11;
  localparam logic [7:0] LCD_TIMER_TOP = 8'hFF;
endpackage

// ==== inc/lcd_fifo_if.sv ====
// stream carrier between front end and fifo and decoder
`timescale 1ns/10ps
interface lcd_fifo_if;
  logic valid;
  logic ready;
  logic [lcd_pkg::LCD_FIFO_WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ==== verilog/lcd_fifo.sv ====
// parameterised fifo for captured write transfers
`timescale 1ns/10ps
module lcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  lcd_fifo_if.snk in_s,
  lcd_fifo_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] count;
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic push;
  logic pop;
  assign in_s.ready = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count <= '0;
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      if (pop) rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) mem[wptr] <= in_s.data;
  end
  a_fifo_no_over: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (count == (AW+1)'(DEPTH)) |-> !push) else $error("fifo overflow");
  c_fifo_full: cover property (@(posedge i_clk) disable iff (!i_resetn)
    count == (AW+1)'(DEPTH));
endmodule

// ==== verilog/lcd_ram.sv ====
// display data ram with registered read port
`timescale 1ns/10ps
module lcd_ram (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [lcd_pkg::LCD_RAM_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [lcd_pkg::LCD_RAM_WORDS];
  always_ff @(posedge i_clk) begin
    if (i_we) mem[i_addr] <= i_wdata;
    o_rdata <= mem[i_addr];
  end
endmodule

// ==== verification/lcd_host_model.sv ====
// host microprocessor model on the parallel and serial bus
`timescale 1ns/10ps
module lcd_host_model (
  input wire logic i_clk,
  input wire logic [1:0] i_mode,
  input wire logic [7:0] i_rdata,
  output logic o_cs_n,
  output logic o_cmd_data_select,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_data,
  output logic o_sclk,
  output logic o_sdata
);
  initial begin
    o_cs_n = 1'b1;
    o_cmd_data_select = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 8'h00;
    o_sclk = 1'b0;
    o_sdata = 1'b0;
  end

  // -------------------------------------------------------------
  // one transfer; serial clock stands still outside frames
  // -------------------------------------------------------------
  task automatic xfer(input logic a0, input logic rd,
                      input logic [7:0] wd, output logic [7:0] rv);
    logic m68;
    rv = 8'h00;
    @(posedge i_clk);
    // mode read after the edge, so a mode set just before is seen
    m68 = (i_mode == 2'h1);
    o_cs_n <= 1'b0;
    o_cmd_data_select <= a0;
    o_data <= wd;
    o_rd_n <= !m68;
    o_wr_n <= m68 ? rd : 1'b1;
    if (i_mode == 2'h2) begin
      for (int i = 7; i >= 0; i--) begin
        o_sdata <= wd[i];
        repeat (2) @(posedge i_clk);
        o_sclk <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_sclk <= 1'b0;
      end
    end else begin
      @(posedge i_clk);
      if (m68) o_rd_n <= 1'b1;
      else if (rd) o_rd_n <= 1'b0;
      else o_wr_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      rv = i_rdata;
      o_rd_n <= !m68;
      o_wr_n <= m68 ? rd : 1'b1;
    end
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    // released lines show the inverse, not a stale value
    o_data <= ~wd;
    o_sdata <= ~wd[0];
    // spacing lets the decoder drain before the next request
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// ==== verification/tb_lcd_driver_command_reset_logic.sv ====
// self-checking bench of the lcd command and reset logic
`timescale 1ns/10ps
module tb_lcd_driver_command_reset_logic;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_hw_reset_in_n = 1'b0;
  logic [1:0] i_if_mode = 2'h0;
  logic i_cs_n, i_cmd_data_select, i_rd_n, i_wr_n, i_sclk, i_sdata;
  logic [7:0] i_data, o_data, o_column;
  logic o_data_oe, o_display_on, o_invert, o_seg_reverse, o_bias_alt;
  logic o_all_on, o_power_save, o_rmw, o_com_reverse, o_test_mode;
  logic o_display_clock_out, o_frame_polarity_out;
  logic o_static_drive_out, o_display_blank_out_n;
  logic [2:0] o_power_ctrl, o_reg_ratio;
  logic [1:0] o_static_ind;
  logic [5:0] o_start_line, o_volume;
  logic [3:0] o_page;
  logic [7:0] grp_a, grp_b, timing, v, c, addr_or;
  logic [5:0] ln;
  logic [3:0] pg;
  int n_errors = 0;
  int checked = 0;

  always #2.5 i_clk = ~i_clk;
  // soft reset keeps group a and clears group b
  assign grp_a = {o_display_on, o_invert, o_seg_reverse, o_power_ctrl,
                  o_bias_alt, o_all_on};
  assign grp_b = {o_rmw, o_static_ind, o_com_reverse, o_reg_ratio,
                  o_test_mode};
  assign timing = {4'h0, o_display_clock_out, o_frame_polarity_out,
                   o_static_drive_out, o_display_blank_out_n};
  assign addr_or = {o_start_line, 2'h0} | o_column | {4'h0, o_page};

  lcd_ctrl DUT (.i_clk, .i_resetn, .i_hw_reset_in_n, .i_if_mode, .i_cs_n,
    .i_cmd_data_select, .i_rd_n, .i_wr_n, .i_data, .i_sclk, .i_sdata,
    .o_data, .o_data_oe, .o_display_on, .o_invert, .o_seg_reverse,
    .o_power_ctrl, .o_bias_alt, .o_all_on, .o_power_save, .o_rmw,
    .o_static_ind, .o_start_line, .o_page, .o_column, .o_com_reverse,
    .o_reg_ratio, .o_volume, .o_test_mode, .o_display_clock_out,
    .o_frame_polarity_out, .o_static_drive_out, .o_display_blank_out_n);

  lcd_host_model HOST (.i_clk, .i_mode(i_if_mode), .i_rdata(o_data),
    .o_cs_n(i_cs_n), .o_cmd_data_select(i_cmd_data_select),
    .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_data(i_data), .o_sclk(i_sclk),
    .o_sdata(i_sdata));

  // -------------------------------------------------------------
  // compares, bus helpers and expectations
  // -------------------------------------------------------------
  task automatic chk_state(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bus(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch read %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic a0, input logic [7:0] d);
    logic [7:0] x;
    HOST.xfer(a0, 1'b0, d, x);
  endtask

  task automatic set_col(input logic [7:0] col);
    wr(1'b0, {lcd_pkg::LCD_COLH_TAG, col[7:4]});
    wr(1'b0, {lcd_pkg::LCD_COLL_TAG, col[3:0]});
  endtask

  function automatic logic [7:0] exp_status(input logic segment_outputs, input logic on);
    return {1'b0, segment_outputs, ~on, 1'b0, 4'h0};
  endfunction

  function automatic logic [7:0] sat_col(input logic [7:0] s, input int n);
    return (int'(s) + n > 131) ? 8'h83 : s + 8'(n);
  endfunction

  task automatic print_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #50000;
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end

  initial begin
    void'($urandom(32'h17128F06));
    repeat (6) @(posedge i_clk);
    chk_state("timing in reset", 8'h0F, timing);
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    i_hw_reset_in_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk_state("group a", 8'h00, grp_a);
    chk_state("power save", 8'h00, {7'h0, o_power_save});
    chk_state("group b", 8'h00, grp_b);
    chk_state("addr", 8'h00, addr_or);
    chk_state("volume", 8'h20, {2'h0, o_volume});
    $display("test reset defaults done");
    for (int m = 0; m < 3; m++) begin
      i_if_mode <= 2'(m);
      wr(1'b0, 8'hAF);
      chk_state("display on", 8'h01, {7'h0, o_display_on});
      wr(1'b0, 8'hAE);
      chk_state("display off", 8'h00, {7'h0, o_display_on});
    end
    $display("test display on off done");
    for (int m = 0; m < 2; m++) begin
      i_if_mode <= 2'(m);
      wr(1'b0, 8'hA1);
      wr(1'b0, 8'hAF);
      HOST.xfer(1'b0, 1'b1, 8'h00, v);
      chk_bus("status", exp_status(1'b1, 1'b1), v);
      chk_state("oe released", 8'h00, {7'h0, o_data_oe});
      wr(1'b0, 8'hAE);
      HOST.xfer(1'b0, 1'b1, 8'h00, v);
      chk_bus("status off", exp_status(1'b1, 1'b0), v);
    end
    $display("test status done");
    for (int k = 0; k < 6; k++) begin
      i_if_mode <= 2'(k % 3);
      ln = 6'($urandom);
      pg = 4'($urandom_range(7));
      c = (k == 0) ? 8'h83 : 8'($urandom_range(131));
      wr(1'b0, {lcd_pkg::LCD_LINE_TAG, ln});
      wr(1'b0, {lcd_pkg::LCD_PAGE_TAG, pg});
      set_col(c);
      chk_state("start line", {2'h0, ln}, {2'h0, o_start_line});
      chk_state("page", {4'h0, pg}, {4'h0, o_page});
      chk_state("column", c, o_column);
    end
    i_if_mode <= 2'h0;
    HOST.xfer(1'b0, 1'b1, 8'h00, v);
    chk_bus("status after page", exp_status(1'b1, 1'b0), v);
    $display("test address set done");
    set_col(8'h81);
    for (int k = 1; k <= 3; k++) begin
      wr(1'b1, 8'h5A);
      chk_state("column inc", sat_col(8'h81, k), o_column);
    end
    chk_state("page kept", {4'h0, pg}, {4'h0, o_page});
    v = 8'($urandom);
    set_col(8'h10);
    wr(1'b1, v);
    set_col(8'h10);
    HOST.xfer(1'b1, 1'b1, 8'h00, c);
    HOST.xfer(1'b1, 1'b1, 8'h00, c);
    chk_bus("ram data", v, c);
    $display("test column and ram done");
    wr(1'b0, 8'hA7);
    wr(1'b0, 8'hA3);
    wr(1'b0, 8'h2F);
    wr(1'b0, 8'hA5);
    wr(1'b0, 8'hAF);
    wr(1'b0, 8'hAE);
    chk_state("power save", 8'h01, {7'h0, o_power_save});
    wr(1'b0, 8'hE0);
    wr(1'b0, 8'hC8);
    wr(1'b0, 8'h81);
    wr(1'b0, 8'h05);
    wr(1'b0, 8'h55);
    chk_state("group a set", 8'h7F, grp_a);
    chk_state("group b set", 8'h90, grp_b);
    chk_state("volume set", 8'h05, {2'h0, o_volume});
    wr(1'b0, lcd_pkg::LCD_CMD_RESET);
    chk_state("group a kept", 8'h7F, grp_a);
    chk_state("power save kept", 8'h01, {7'h0, o_power_save});
    chk_state("group b soft", 8'h00, grp_b);
    chk_state("addr soft", 8'h00, addr_or);
    chk_state("volume soft", 8'h20, {2'h0, o_volume});
    $display("test soft reset done");
    @(posedge i_clk);
    i_hw_reset_in_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk_state("timing in pin reset", 8'h0F, timing);
    i_hw_reset_in_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk_state("group a pin", 8'h00, grp_a);
    chk_state("power save pin", 8'h00, {7'h0, o_power_save});
    $display("test pin reset done");
    print_verdict();
  end
endmodule
